//--- rtl/wdev_pkg.sv
// Package with constants and carrier types for the watchdog and event-input block
package wdev_pkg;
    localparam int CLK_HZ = 10000000;
    localparam int HW_WINDOW_MS = 200;
    localparam int SW_WINDOW_MS = 200;
    localparam int HW_WINDOW_CYC = HW_WINDOW_MS * (CLK_HZ / 1000);
    localparam int SW_WINDOW_CYC = SW_WINDOW_MS * (CLK_HZ / 1000);
    localparam int RESP_MS = 1;
    localparam int RESP_CYC = RESP_MS * (CLK_HZ / 1000);
    localparam int N_EVT = 4;
    localparam logic [7:0] EVT_HANDLER_BASE = 8'h14;
    localparam logic [7:0] EXC_HANDLER_ZERO = 8'h00;
    localparam logic [7:0] WDOG_OUT_ADDR = 8'hFF;
    localparam logic [1:0] SWWD_OFF = 2'h0;
    localparam logic [1:0] SWWD_COLD = 2'h1;
    localparam logic [1:0] SWWD_EXC = 2'h2;
    localparam logic [15:0] SYSCMD_WDOG = 16'h03E8;
    // Avalon word offsets (byte addresses)
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_IRQ_STAT = 4'h4;
    localparam logic [3:0] REG_IRQ_MASK = 4'h8;
    localparam logic [3:0] REG_SYSCMD = 4'hC;
    // Status fields
    localparam int ST_EVT_LSB = 0;
    localparam int ST_RELAY = 4;
    localparam int ST_SW_ARMED = 5;
    localparam int ST_SW_MODE_LSB = 6;
    // Interrupt status fields
    localparam int IRQ_EVT_LSB = 0;
    localparam int IRQ_HWWD = 4;
    localparam int IRQ_SWWD = 5;
    localparam int IRQ_W = 6;
    // History cause codes
    localparam logic [1:0] CAUSE_NONE = 2'h0;
    localparam logic [1:0] CAUSE_WDOG = 2'h1;
    localparam logic [1:0] CAUSE_SUPPLY = 2'h2;

    typedef struct packed {
        logic valid;
        logic [7:0] number;
        logic [1:0] cause;
    } wdev_call_t;

    typedef struct packed {
        logic write;
        logic [7:0] addr;
        logic value;
    } wdev_io_t;
endpackage : wdev_pkg

//--- rtl/wdev_top.sv
// Watchdog relays, software watchdog and edge event inputs with Avalon-MM registers
`timescale 1ns/1ps
// What this block does
// [RULE_01] The relay stays energised only while the supervised output changes at least every 200 ms.
// [RULE_02] If the supervised output stops changing in time the relay drops and the amber indicator goes off.
// [RULE_03] The relay state reads back as a status bit that is 1 while the relay is energised.
// [RULE_04] A program whose cycle exceeds 200 ms must toggle the supervised output several times per cycle.
// [RULE_05] Writes to the supervised output address are never passed to digital I/O modules.
// [RULE_06] The integrator keeps analogue, counter and motion modules off the colliding socket.
// [RULE_07] The first watchdog command arms the software watchdog, which must then be reissued every 200 ms.
// [RULE_08] A watchdog command with parameter zero disarms the software watchdog.
// [RULE_09] Parameter one arms it and a missed 200 ms refresh causes a cold start.
// [RULE_10] Parameter two arms it and a missed refresh first calls exception handler zero, then cold starts.
// [RULE_11] Every exception handler zero call is logged with its cause, watchdog or supply fault.
// [RULE_12] A rising edge on event input n calls handler 20 plus n.
// [RULE_13] The handler starts within 1 ms of the edge at summed input rates up to 1 kHz.
// [RULE_14] Each rising edge sets its query bit whether or not a handler exists.
// [RULE_15] Handler routines are kept short so the rest of the program still runs.
// [RULE_16] Each event input is synchronised and its edge found from registered samples, one event per edge.
// [RULE_17] Any change of the supervised output level restarts the 200 ms hardware window.
module wdev_top #(
    parameter int HW_WINDOW = wdev_pkg::HW_WINDOW_CYC,
    parameter int SW_WINDOW = wdev_pkg::SW_WINDOW_CYC
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // Avalon-MM slave
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output logic o_avs_response_err,
    // Program I/O write port
    input wire wdev_pkg::wdev_io_t i_io,
    output wdev_pkg::wdev_io_t o_dio,
    // Field pins
    input wire logic [wdev_pkg::N_EVT-1:0] i_evt,
    input wire logic i_supply_fault,
    output logic o_relay_on,
    output logic o_amber_led,
    // Handler calls and restart
    output wdev_pkg::wdev_call_t o_call,
    input wire logic i_call_ack,
    output logic o_cold_start,
    output logic [1:0] o_hist_cause,
    output logic o_hist_valid,
    // Interrupt
    output logic o_irq
);
    localparam int N = wdev_pkg::N_EVT;

    logic rst_m_q, rst_s_q;
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_m_q <= 1'b0;
            rst_s_q <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_s_q <= rst_m_q;
        end
    end
    wire rstn = rst_s_q;

    // Event input synchroniser and edge detect
    logic [N-1:0] ev_m_q, ev_s_q, ev_p_q, ev_rise;
    always_ff @(posedge i_ref_clk or negedge rstn) begin
        if (!rstn) begin
            ev_m_q <= '0;
            ev_s_q <= '0;
            ev_p_q <= '0;
        end else begin
            ev_m_q <= i_evt;
            ev_s_q <= ev_m_q; // RULE_16
            ev_p_q <= ev_s_q;
        end
    end
    assign ev_rise = ev_s_q & ~ev_p_q; // RULE_16

    // Register bus decode
    logic rd_acc, wr_acc, rd_stat, rd_irq, cmd_wr, rd_take, rd_hold_q, rd_hold_d;
    assign rd_acc = i_avs_read && !i_avs_write;
    assign wr_acc = i_avs_write && !i_avs_read;
    // One wait state per read so registered readdata stands at the accepting edge
    assign rd_take = rd_acc && !rd_hold_q;
    assign rd_stat = rd_take && i_avs_address == wdev_pkg::REG_STATUS;
    assign rd_irq = rd_take && i_avs_address == wdev_pkg::REG_IRQ_STAT;
    assign cmd_wr = wr_acc && i_avs_address == wdev_pkg::REG_SYSCMD && (&i_avs_byteenable)
        && i_avs_writedata[31:16] == wdev_pkg::SYSCMD_WDOG;

    // Hardware watchdog
    logic hw_lvl_q, hw_lvl_d, relay_q, relay_d, hw_trip;
    logic [31:0] hw_cnt_q, hw_cnt_d;
    logic sup_wr;
    assign sup_wr = i_io.write && i_io.addr == wdev_pkg::WDOG_OUT_ADDR;
    always_comb begin
        hw_lvl_d = sup_wr ? i_io.value : hw_lvl_q;
        hw_cnt_d = hw_cnt_q;
        relay_d = relay_q;
        hw_trip = 1'b0;
        if (sup_wr && i_io.value != hw_lvl_q) begin
            hw_cnt_d = '0; // RULE_17
            relay_d = 1'b1; // RULE_01
        end else if (relay_q) begin
            if (hw_cnt_q >= 32'(HW_WINDOW - 1)) begin
                relay_d = 1'b0; // RULE_02
                hw_trip = 1'b1;
            end else begin
                hw_cnt_d = hw_cnt_q + 32'h1;
            end
        end
    end
    always_ff @(posedge i_ref_clk or negedge rstn) begin
        if (!rstn) begin
            hw_lvl_q <= 1'b0;
            hw_cnt_q <= '0;
            relay_q <= 1'b0;
        end else begin
            hw_lvl_q <= hw_lvl_d;
            hw_cnt_q <= hw_cnt_d;
            relay_q <= relay_d;
        end
    end
    assign o_relay_on = relay_q;
    assign o_amber_led = relay_q; // RULE_02

    // Writes to the supervised address never reach digital modules
    logic dio_w_q;
    logic [7:0] dio_a_q;
    logic dio_v_q;
    always_ff @(posedge i_ref_clk or negedge rstn) begin
        if (!rstn) begin
            dio_w_q <= 1'b0;
            dio_a_q <= 8'h00;
            dio_v_q <= 1'b0;
        end else begin
            dio_w_q <= i_io.write && !sup_wr; // RULE_05
            dio_a_q <= i_io.addr;
            dio_v_q <= i_io.value;
        end
    end
    assign o_dio = '{write: dio_w_q, addr: dio_a_q, value: dio_v_q};

    // Software watchdog
    logic [1:0] sw_mode_q, sw_mode_d;
    logic [31:0] sw_cnt_q, sw_cnt_d;
    logic sw_trip, sw_exc;
    always_comb begin
        sw_mode_d = sw_mode_q;
        sw_cnt_d = sw_cnt_q;
        sw_trip = 1'b0;
        sw_exc = 1'b0;
        if (cmd_wr) begin
            sw_cnt_d = '0; // RULE_07
            if (i_avs_writedata[1:0] == wdev_pkg::SWWD_OFF) begin
                sw_mode_d = wdev_pkg::SWWD_OFF; // RULE_08
            end else if (i_avs_writedata[1:0] <= wdev_pkg::SWWD_EXC) begin
                sw_mode_d = i_avs_writedata[1:0];
            end
        end else if (sw_mode_q != wdev_pkg::SWWD_OFF) begin
            if (sw_cnt_q >= 32'(SW_WINDOW - 1)) begin
                sw_trip = 1'b1; // RULE_09
                sw_exc = sw_mode_q == wdev_pkg::SWWD_EXC; // RULE_10
                sw_mode_d = wdev_pkg::SWWD_OFF;
                sw_cnt_d = '0;
            end else begin
                sw_cnt_d = sw_cnt_q + 32'h1;
            end
        end
    end
    always_ff @(posedge i_ref_clk or negedge rstn) begin
        if (!rstn) begin
            sw_mode_q <= wdev_pkg::SWWD_OFF;
            sw_cnt_q <= '0;
        end else begin
            sw_mode_q <= sw_mode_d;
            sw_cnt_q <= sw_cnt_d;
        end
    end

    // Handler dispatch: exception zero first, then a pending cold start (which drops pending events), then events in index order
    typedef enum logic [2:0] {
        WDEV_IDLE = 3'b001,
        WDEV_CALL = 3'b010,
        WDEV_COLD = 3'b100
    } wdev_state_t;
    wdev_state_t st_q, st_d;
    logic [N-1:0] pend_q, pend_d, qry_q, qry_d;
    logic exc_q, exc_d, cold_pend_q, cold_pend_d, sup_p_q, sup_rise;
    wdev_pkg::wdev_call_t call_q, call_d;
    logic cold_q, cold_d, hv_q, hv_d;
    logic [1:0] hc_q, hc_d;
    assign sup_rise = i_supply_fault && !sup_p_q;
    always_comb begin
        st_d = st_q;
        pend_d = pend_q | ev_rise;
        qry_d = (rd_stat ? '0 : qry_q) | ev_rise; // RULE_14
        exc_d = exc_q;
        cold_pend_d = cold_pend_q | sw_trip; // RULE_09
        call_d = call_q;
        cold_d = 1'b0;
        hv_d = 1'b0;
        hc_d = hc_q;
        if (sw_exc) begin
            exc_d = 1'b1;
            hc_d = wdev_pkg::CAUSE_WDOG; // RULE_11
            hv_d = 1'b1;
        end else if (sup_rise) begin
            exc_d = 1'b1;
            hc_d = wdev_pkg::CAUSE_SUPPLY; // RULE_11
            hv_d = 1'b1;
        end
        unique case (st_q)
            WDEV_IDLE: begin
                if (exc_q) begin
                    call_d = '{valid: 1'b1, number: wdev_pkg::EXC_HANDLER_ZERO, cause: hc_q}; // RULE_10
                    exc_d = 1'b0;
                    st_d = WDEV_CALL;
                end else if (cold_pend_q) begin
                    st_d = WDEV_COLD;
                end else begin
                    for (int k = N - 1; k >= 0; k--) begin
                        if (pend_q[k]) begin
                            call_d = '{valid: 1'b1, number: wdev_pkg::EVT_HANDLER_BASE + 8'(k),
                                cause: wdev_pkg::CAUSE_NONE}; // RULE_12
                        end
                    end
                    if (|pend_q) begin
                        pend_d = (pend_q & ~(pend_q & -pend_q)) | ev_rise; // RULE_13
                        st_d = WDEV_CALL;
                    end
                end
            end
            WDEV_CALL: begin
                if (i_call_ack) begin
                    call_d.valid = 1'b0;
                    st_d = WDEV_IDLE;
                end
            end
            WDEV_COLD: begin
                cold_d = 1'b1;
                cold_pend_d = 1'b0;
                pend_d = '0;
                st_d = WDEV_IDLE;
            end
        endcase
    end
    always_ff @(posedge i_ref_clk or negedge rstn) begin
        if (!rstn) begin
            st_q <= WDEV_IDLE;
            pend_q <= '0;
            qry_q <= '0;
            exc_q <= 1'b0;
            cold_pend_q <= 1'b0;
            call_q <= '0;
            cold_q <= 1'b0;
            hv_q <= 1'b0;
            hc_q <= wdev_pkg::CAUSE_NONE;
            sup_p_q <= 1'b0;
        end else begin
            st_q <= st_d;
            pend_q <= pend_d;
            qry_q <= qry_d;
            exc_q <= exc_d;
            cold_pend_q <= cold_pend_d;
            call_q <= call_d;
            cold_q <= cold_d;
            hv_q <= hv_d;
            hc_q <= hc_d;
            sup_p_q <= i_supply_fault;
        end
    end
    assign o_call = call_q;
    assign o_cold_start = cold_q;
    assign o_hist_valid = hv_q;
    assign o_hist_cause = hc_q;

    // Interrupt status, mask and read data
    logic [wdev_pkg::IRQ_W-1:0] ist_q, ist_d, imask_q, imask_d, iev;
    logic [31:0] rdata_q, rdata_d;
    logic err_q, err_d;
    assign iev = {sw_trip, hw_trip, ev_rise};
    always_comb begin
        ist_d = (rd_irq ? '0 : ist_q) | iev;
        imask_d = imask_q;
        if (wr_acc && i_avs_address == wdev_pkg::REG_IRQ_MASK && i_avs_byteenable[0]) begin
            imask_d = i_avs_writedata[wdev_pkg::IRQ_W-1:0];
        end
        rdata_d = 32'h0;
        err_d = 1'b0;
        rd_hold_d = rd_take;
        if (rd_take) begin
            unique case (i_avs_address)
                wdev_pkg::REG_STATUS: begin
                    rdata_d[wdev_pkg::ST_EVT_LSB +: N] = qry_q;
                    rdata_d[wdev_pkg::ST_RELAY] = relay_q; // RULE_03
                    rdata_d[wdev_pkg::ST_SW_ARMED] = sw_mode_q != wdev_pkg::SWWD_OFF;
                    rdata_d[wdev_pkg::ST_SW_MODE_LSB +: 2] = sw_mode_q;
                end
                wdev_pkg::REG_IRQ_STAT: rdata_d[wdev_pkg::IRQ_W-1:0] = ist_q;
                wdev_pkg::REG_IRQ_MASK: rdata_d[wdev_pkg::IRQ_W-1:0] = imask_q;
                wdev_pkg::REG_SYSCMD: rdata_d = 32'h0;
                default: err_d = 1'b1;
            endcase
        end
    end
    always_ff @(posedge i_ref_clk or negedge rstn) begin
        if (!rstn) begin
            ist_q <= '0;
            imask_q <= '0;
            rdata_q <= 32'h0;
            err_q <= 1'b0;
            rd_hold_q <= 1'b0;
        end else begin
            ist_q <= ist_d;
            imask_q <= imask_d;
            rdata_q <= rdata_d;
            err_q <= err_d;
            rd_hold_q <= rd_hold_d;
        end
    end
    assign o_avs_readdata = rdata_q;
    assign o_avs_response_err = err_q;
    assign o_avs_waitrequest = rd_take;
    assign o_irq = |(ist_q & imask_q);

    chk_relay_drop: assert property (@(posedge i_ref_clk) disable iff (!rstn)
        hw_trip |=> !o_relay_on && !o_amber_led) else $error("relay still on after trip"); // RULE_02
    chk_relay_toggle: assert property (@(posedge i_ref_clk) disable iff (!rstn)
        (sup_wr && i_io.value != hw_lvl_q) |=> o_relay_on && hw_cnt_q == 0) else $error("toggle ignored"); // RULE_17
    chk_relay_window: assert property (@(posedge i_ref_clk) disable iff (!rstn)
        o_relay_on |-> hw_cnt_q < 32'(HW_WINDOW)) else $error("relay beyond window"); // RULE_01
    chk_dio_block: assert property (@(posedge i_ref_clk) disable iff (!rstn)
        sup_wr |=> !o_dio.write) else $error("supervised address leaked"); // RULE_05
    chk_sw_disarm: assert property (@(posedge i_ref_clk) disable iff (!rstn)
        (cmd_wr && i_avs_writedata[1:0] == wdev_pkg::SWWD_OFF) |=> sw_mode_q == wdev_pkg::SWWD_OFF
        ##1 !sw_trip) else $error("disarm failed"); // RULE_08
    chk_sw_cold: assert property (@(posedge i_ref_clk) disable iff (!rstn)
        (sw_trip && !sw_exc) |-> ##[1:3] o_cold_start) else $error("no cold start"); // RULE_09
    chk_sw_exc: assert property (@(posedge i_ref_clk) disable iff (!rstn)
        (sw_trip && sw_exc && st_q == WDEV_IDLE) |=> ##1 o_call.valid && o_call.number == 8'h00)
        else $error("exception zero not called"); // RULE_10
    chk_hist_log: assert property (@(posedge i_ref_clk) disable iff (!rstn)
        sw_exc |=> o_hist_valid && o_hist_cause == wdev_pkg::CAUSE_WDOG) else $error("history missing"); // RULE_11
    chk_evt_query: assert property (@(posedge i_ref_clk) disable iff (!rstn)
        ev_rise[0] |=> qry_q[0]) else $error("query bit not set"); // RULE_14
    chk_evt_once: assert property (@(posedge i_ref_clk) disable iff (!rstn)
        ev_rise[0] |=> !ev_rise[0]) else $error("double event"); // RULE_16
    chk_evt_call: assert property (@(posedge i_ref_clk) disable iff (!rstn)
        (ev_rise == 4'h1 && st_q == WDEV_IDLE && pend_q == 0 && !exc_q && !cold_pend_q && !sw_trip)
        |=> ##1 o_call.valid && o_call.number == 8'h14) else $error("handler 20 not called"); // RULE_12
endmodule : wdev_top

//--- tb/wdev_field.sv
// Field side model: event contacts, supply monitor and watchdog relay contact
`timescale 1ns/1ps
module wdev_field (
    // Clock
    input wire logic i_ref_clk,
    // Relay coil from the device
    input wire logic i_relay_on,
    // Field signals to the device
    output logic [wdev_pkg::N_EVT-1:0] o_evt,
    output logic o_supply_fault,
    output logic o_contact_closed
);
    initial begin
        o_evt = '0;
        o_supply_fault = 1'b0;
    end
    // Nothing else hangs on the colliding socket, only this contact
    assign o_contact_closed = i_relay_on;
    // Contacts close for a few cycles and open again, far above the 1 kHz summed input rate
    task automatic pulse(input logic [3:0] which, input int width);
        @(posedge i_ref_clk);
        o_evt <= which;
        repeat (width) @(posedge i_ref_clk);
        o_evt <= '0;
    endtask : pulse
    task automatic fault(input int width);
        @(posedge i_ref_clk);
        o_supply_fault <= 1'b1;
        repeat (width) @(posedge i_ref_clk);
        o_supply_fault <= 1'b0;
    endtask : fault
endmodule : wdev_field

//--- tb/wdev_tb_top.sv
// Self-checking bench for the watchdog and event-input block
`timescale 1ns/1ps
module wdev_tb_top;
    localparam int WIN = 100;
    localparam int LIMIT = 50000;
    logic i_ref_clk, i_rstn, i_avs_read, i_avs_write, i_call_ack, i_supply_fault;
    logic [3:0] i_avs_address, i_avs_byteenable, i_evt;
    logic [31:0] i_avs_writedata, o_avs_readdata;
    logic o_avs_waitrequest, o_avs_response_err, o_relay_on, o_amber_led;
    logic o_cold_start, o_hist_valid, o_irq, contact;
    logic [1:0] o_hist_cause;
    logic [1:0] last_cause = 2'h0;
    logic [7:0] ra;
    wdev_pkg::wdev_io_t i_io, o_dio;
    wdev_pkg::wdev_call_t o_call;
    int n_fail = 0;
    int tests_run = 0;
    int cycles = 0;
    int n_cold = 0;
    int seed, c;
    int exp_calls[$];

    wdev_top #(.HW_WINDOW(WIN), .SW_WINDOW(WIN)) wdev_top_i (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn),
        .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
        .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
        .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
        .o_avs_response_err(o_avs_response_err), .i_io(i_io), .o_dio(o_dio), .i_evt(i_evt),
        .i_supply_fault(i_supply_fault), .o_relay_on(o_relay_on), .o_amber_led(o_amber_led),
        .o_call(o_call), .i_call_ack(i_call_ack), .o_cold_start(o_cold_start),
        .o_hist_cause(o_hist_cause), .o_hist_valid(o_hist_valid), .o_irq(o_irq));
    wdev_field wdev_field_i (.i_ref_clk(i_ref_clk), .i_relay_on(o_relay_on), .o_evt(i_evt),
        .o_supply_fault(i_supply_fault), .o_contact_closed(contact));

    initial begin
        i_ref_clk = 1'b0;
        forever #50 i_ref_clk = ~i_ref_clk;
    end

    always @(posedge i_ref_clk) begin
        cycles <= cycles + 1;
        if (o_cold_start === 1'b1) n_cold <= n_cold + 1;
        if (o_hist_valid === 1'b1) last_cause <= o_hist_cause;
        if (cycles == LIMIT) begin
            n_fail = n_fail + 1;
            $display("MISMATCH run length expected below %0d seen %0d", LIMIT, cycles);
            conclude();
        end
    end

    task automatic check(input string w, input logic [31:0] seen, input logic [31:0] e);
        tests_run++;
        if (seen !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", w, e, seen);
        end
    endtask : check

    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    task automatic av_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_write <= 1'b1;
        @(posedge i_ref_clk);
        while (o_avs_waitrequest !== 1'b0) @(posedge i_ref_clk);
        i_avs_write <= 1'b0;
    endtask : av_wr

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e, input string w);
        @(posedge i_ref_clk);
        i_avs_address <= a;
        i_avs_read <= 1'b1;
        @(posedge i_ref_clk);
        while (o_avs_waitrequest !== 1'b0) @(posedge i_ref_clk);
        check(w, o_avs_readdata & m, e);
        check("read error flag", 32'(o_avs_response_err), 32'(a[1:0] != 2'h0));
        i_avs_read <= 1'b0;
    endtask : rd_chk

    task automatic io_wr(input logic [7:0] a, input logic v);
        @(posedge i_ref_clk);
        i_io <= '{1'b1, a, v};
        @(posedge i_ref_clk);
        i_io.write <= 1'b0;
        @(posedge i_ref_clk);
        check("io pass-through", 32'(o_dio.write), 32'(a != 8'hFF));
        check("io address", 32'(o_dio.addr), 32'(a));
        check("io value", 32'(o_dio.value), 32'(v));
    endtask : io_wr

    task automatic take_call(input string w);
        int k;
        logic [31:0] e;
        k = 0;
        e = exp_calls.pop_front();
        @(posedge i_ref_clk);
        while (o_call.valid !== 1'b1 && k < wdev_pkg::RESP_CYC) begin
            @(posedge i_ref_clk);
            k++;
        end
        check("call pending", 32'(o_call.valid), 32'h1);
        check(w, {22'h0, o_call.cause, o_call.number}, e);
        // Handlers return at once so the program keeps running
        i_call_ack <= 1'b1;
        @(posedge i_ref_clk);
        i_call_ack <= 1'b0;
    endtask : take_call

    initial begin
        seed = 32'h0dbfc037;
        i_rstn = 1'b0;
        {i_avs_read, i_avs_write, i_call_ack} = 3'h0;
        i_avs_address = 4'h0;
        i_avs_writedata = 32'h0;
        i_avs_byteenable = 4'hF;
        i_io = '0;
        repeat (2) @(posedge i_ref_clk);
        i_rstn <= 1'b1;
        repeat (3) @(posedge i_ref_clk);
        rd_chk(wdev_pkg::REG_STATUS, 32'hFFFFFFFF, 32'h0, "status after reset");
        rd_chk(wdev_pkg::REG_IRQ_MASK, 32'hFFFFFFFF, 32'h0, "mask after reset");
        av_wr(wdev_pkg::REG_IRQ_MASK, 32'h3F);
        rd_chk(wdev_pkg::REG_IRQ_MASK, 32'hFFFFFFFF, 32'h3F, "mask readback");
        rd_chk(4'h2, 32'hFFFFFFFF, 32'h0, "unmapped read");
        $display("Register test finished");
        for (int i = 0; i < 7; i++) begin
            io_wr(8'hFF, ~i[0]);
            ra = 8'($random(seed));
            io_wr((ra == 8'hFF) ? 8'h00 : ra, ra[0]);
            repeat (40) @(posedge i_ref_clk);
            check("relay held", 32'(o_relay_on), 32'h1);
            check("amber held", 32'(o_amber_led), 32'h1);
        end
        io_wr(8'hFF, 1'b0);
        rd_chk(wdev_pkg::REG_STATUS, 32'h10, 32'h10, "relay status bit");
        repeat (75) @(posedge i_ref_clk);
        check("relay after restart", 32'(o_relay_on), 32'h1);
        io_wr(8'hFF, 1'b0);
        repeat (30) @(posedge i_ref_clk);
        check("relay dropped", 32'(o_relay_on), 32'h0);
        check("amber dropped", 32'(o_amber_led), 32'h0);
        check("contact open", 32'(contact), 32'h0);
        check("trip irq", 32'(o_irq), 32'h1);
        rd_chk(wdev_pkg::REG_IRQ_STAT, 32'hFFFFFFFF, 32'h10, "hw trip flag");
        check("irq cleared", 32'(o_irq), 32'h0);
        $display("Hardware watchdog test finished");
        for (int n = 0; n < 4; n++) begin
            exp_calls.push_back(20 + n);
            wdev_field_i.pulse(4'h1 << n, 3 + ($unsigned($random(seed)) % 8));
            take_call("event handler number");
        end
        rd_chk(wdev_pkg::REG_IRQ_STAT, 32'hFFFFFFFF, 32'hF, "event irq flags");
        wdev_field_i.pulse(4'hF, 12);
        for (int n = 0; n < 4; n++) exp_calls.push_back(20 + n);
        repeat (4) take_call("lowest event first");
        repeat (20) @(posedge i_ref_clk);
        check("one call per edge", 32'(o_call.valid), 32'h0);
        rd_chk(wdev_pkg::REG_STATUS, 32'hF, 32'hF, "event query bits");
        rd_chk(wdev_pkg::REG_STATUS, 32'hF, 32'h0, "query bits cleared");
        $display("Event input test finished");
        av_wr(wdev_pkg::REG_SYSCMD, 32'h12340001);
        rd_chk(wdev_pkg::REG_STATUS, 32'hE0, 32'h0, "bad command ignored");
        c = n_cold;
        for (int i = 0; i < 3; i++) begin
            av_wr(wdev_pkg::REG_SYSCMD, {wdev_pkg::SYSCMD_WDOG, 14'h0, wdev_pkg::SWWD_COLD});
            repeat (80) @(posedge i_ref_clk);
        end
        check("no restart while refreshed", n_cold, c);
        repeat (30) @(posedge i_ref_clk);
        check("cold start on lapse", n_cold, c + 1);
        rd_chk(wdev_pkg::REG_STATUS, 32'h20, 32'h0, "disarmed after trip");
        av_wr(wdev_pkg::REG_SYSCMD, {wdev_pkg::SYSCMD_WDOG, 14'h0, wdev_pkg::SWWD_COLD});
        av_wr(wdev_pkg::REG_SYSCMD, {wdev_pkg::SYSCMD_WDOG, 14'h0, wdev_pkg::SWWD_OFF});
        repeat (150) @(posedge i_ref_clk);
        check("no restart when off", n_cold, c + 1);
        av_wr(wdev_pkg::REG_SYSCMD, {wdev_pkg::SYSCMD_WDOG, 14'h0, wdev_pkg::SWWD_EXC});
        rd_chk(wdev_pkg::REG_STATUS, 32'hE0, 32'hA0, "armed with handler");
        exp_calls.push_back(32'(wdev_pkg::CAUSE_WDOG) << 8);
        take_call("exception zero on lapse");
        check("history cause watchdog", 32'(last_cause), 32'(wdev_pkg::CAUSE_WDOG));
        repeat (20) @(posedge i_ref_clk);
        check("cold start after handler", n_cold, c + 2);
        exp_calls.push_back(32'(wdev_pkg::CAUSE_SUPPLY) << 8);
        wdev_field_i.fault(5);
        take_call("exception zero on supply fault");
        check("history cause supply", 32'(last_cause), 32'(wdev_pkg::CAUSE_SUPPLY));
        rd_chk(wdev_pkg::REG_IRQ_STAT, 32'h20, 32'h20, "sw trip flag");
        $display("Software watchdog test finished");
        conclude();
    end
endmodule : wdev_tb_top
